// file: hdl/ccrpm_dbg.sv
// Purpose: debug reset domain, halt request capture, debug bus strobe
// Assumes: debug reset and bus enable are synchronous to the core clock
// Notes:   never sees the core reset; runs on the ungated clock
`timescale 1ns/100ps
`default_nettype none
module ccrpm_dbg
   import ccrpm_pkg::*;
(
   // clock, reset, enable
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   // debug domain inputs
   input  wire logic dbg_rst_n,
   input  wire logic dbg_bus_en,
   input  wire logic halt_cmd,
   input  wire logic halt_taken,
   input  wire logic ext_req,
   // debug domain outputs
   output var  logic dbg_req,
   output var  logic dbg_rst,
   output var  logic dbg_stb
);

   typedef struct packed {
      logic halt_pend;
      logic req;
      logic rst_o;
      logic stb;
   } ccrpm_dbg_s;

   localparam ccrpm_dbg_s D_RST = '{halt_pend: 1'b0, req: 1'b0,
                                    rst_o: 1'b1, stb: 1'b0};

   ccrpm_dbg_s d_reg;
   ccrpm_dbg_s d_next;

   always_comb begin
      d_next       = d_reg;
      d_next.rst_o = !dbg_rst_n;
      d_next.stb   = dbg_bus_en;
      if (!dbg_rst_n) begin
         d_next.halt_pend = 1'b0;
         d_next.req       = 1'b0;
      end else begin
         // a halt taken in the same cycle as a new command stays pending
         d_next.halt_pend = (d_reg.halt_pend & ~halt_taken)
                          | (halt_cmd & dbg_bus_en);
         d_next.req       = d_next.halt_pend | ext_req;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         d_reg <= D_RST;
      end else if (ce) begin
         d_reg <= d_next;
      end
   end

   assign dbg_req = d_reg.req;
   assign dbg_rst = d_reg.rst_o;
   assign dbg_stb = d_reg.stb;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_dbg_reset_clears: assert property (
      (ce && !dbg_rst_n) |=> (!dbg_req && dbg_rst))
      else $error("debug reset did not clear request");
   chk_halt_capture: assert property (
      (ce && dbg_rst_n && halt_cmd && dbg_bus_en) |=> dbg_req)
      else $error("halt command not turned into request");
   chk_ext_request: assert property (
      (ce && dbg_rst_n && ext_req) |=> dbg_req)
      else $error("external debug request lost");

endmodule
`default_nettype wire

// file: hdl/ccrpm_pkg.sv
// Purpose: shared constants for core clock, reset and power mode control
// Assumes: one core clock; all state machines one-hot
// Notes:   mode codes drive the POWER_MODE status output
package ccrpm_pkg;

   typedef enum logic [6:0] {
      ST_RESET = 7'h01,
      ST_RUN   = 7'h02,
      ST_DRAIN = 7'h04,
      ST_STOP  = 7'h08,
      ST_IDLE  = 7'h10,
      ST_DORM  = 7'h20,
      ST_WAKE  = 7'h40
   } ccrpm_state_e;

   // power mode status codes
   localparam int         MODE_W       = 3;
   localparam logic [2:0] MODE_RUN     = 3'h1;
   localparam logic [2:0] MODE_STANDBY = 3'h2;
   localparam logic [2:0] MODE_DORMANT = 3'h4;

   // gated functional units
   localparam int         N_UNITS_DEF  = 4;

   // synchroniser lanes and their reset values
   localparam int         SYNC_W        = 3;
   localparam int         SYNC_CORE_RST = 0;
   localparam int         SYNC_IRQ      = 1;
   localparam int         SYNC_FIQ      = 2;
   // core reset held, both interrupts idle
   localparam logic [2:0] SYNC_RST_VAL  = 3'h6;

endpackage

// file: hdl/ccrpm_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: each lane is an independent level
// Notes:   first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none
module ccrpm_sync
   import ccrpm_pkg::*;
#(
   parameter int               WIDTH   = SYNC_W,
   parameter logic [WIDTH-1:0] RST_VAL = SYNC_RST_VAL
) (
   // clock, reset, enable
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   // asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] d,
   output var  logic [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } ccrpm_sync_s;

   ccrpm_sync_s s_reg;
   ccrpm_sync_s s_next;

   always_comb begin
      s_next      = s_reg;
      s_next.meta = d;
      s_next.sync = s_reg.meta;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= {RST_VAL, RST_VAL};
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.sync;

endmodule
`default_nettype wire

// file: hdl/ccrpm_top.sv
// Purpose: core clock gating, reset domains and Run/Standby/Dormant control
// Assumes: pipeline reports wait instructions and outstanding accesses
// Notes:   all outputs registered; CE low freezes every flop
`timescale 1ns/100ps
`default_nettype none

module ccrpm_top
   import ccrpm_pkg::*;
#(
   parameter int N_UNITS = N_UNITS_DEF
) (
   // clock, reset, enable
   input  wire logic               CLK_SYS,
   input  wire logic               RST,
   input  wire logic               CE,
   // reset pins
   input  wire logic               CORE_RESET_N,
   input  wire logic               DEBUG_LOGIC_RESET_N,
   // interrupt, wake and clamp pins
   input  wire logic               NORMAL_INTERRUPT_N,
   input  wire logic               FAST_INTERRUPT_N,
   input  wire logic               EXTERNAL_DEBUG_REQUEST,
   input  wire logic               EVENT_WAKE_IN,
   input  wire logic               RAM_ISOLATION_CLAMP,
   // bus clock enables
   input  wire logic               SYSTEM_BUS_CLOCK_ENABLE,
   input  wire logic               DEBUG_BUS_CLOCK_ENABLE,
   // pipeline side
   input  wire logic               WAIT_INTERRUPT_INSTR,
   input  wire logic               WAIT_EVENT_INSTR,
   input  wire logic               MEM_ACCESS_PENDING,
   input  wire logic               DEBUG_HALT_CMD,
   input  wire logic               DEBUG_HALT_TAKEN,
   input  wire logic [N_UNITS-1:0] UNIT_BUSY,
   // standby handshake
   output var  logic               WAIT_INTERRUPT_IDLE_OUT,
   output var  logic               WAIT_EVENT_IDLE_OUT,
   output var  logic               WAIT_INSTR_DONE,
   output var  logic [MODE_W-1:0]  POWER_MODE,
   // clock gating and strobes
   output var  logic               CORE_CLOCK_ENABLE,
   output var  logic [N_UNITS-1:0] UNIT_CLOCK_ENABLE,
   output var  logic               SYSTEM_BUS_STROBE,
   output var  logic               DEBUG_BUS_STROBE,
   // barrier and retention
   output var  logic               BARRIER_BUSY,
   output var  logic               RAM_INPUT_BLOCK,
   // reset and debug
   output var  logic               CORE_RESET_OUT,
   output var  logic               DEBUG_RESET_OUT,
   output var  logic               DEBUG_REQUEST_OUT
);

   typedef struct packed {
      ccrpm_state_e       st;
      logic               wfe_kind;
      logic               evt_pend;
      logic               cke;
      logic               wfi_o;
      logic               wfe_o;
      logic               done;
      logic               core_rst;
      logic               bus_stb;
      logic               ram_blk;
      logic               barrier;
      logic [MODE_W-1:0]  mode;
      logic [N_UNITS-1:0] unit_en;
   } ccrpm_core_s;

   localparam ccrpm_core_s C_RST = '{
      st:       ST_RESET,
      wfe_kind: 1'b0,
      evt_pend: 1'b0,
      cke:      1'b1,
      wfi_o:    1'b0,
      wfe_o:    1'b0,
      done:     1'b0,
      core_rst: 1'b1,
      bus_stb:  1'b0,
      ram_blk:  1'b0,
      barrier:  1'b0,
      mode:     MODE_RUN,
      unit_en:  '0
   };

   ccrpm_core_s         c_reg;
   ccrpm_core_s         c_next;
   logic [SYNC_W-1:0]   sync_q;
   logic                core_ok;
   logic                irq_any;
   logic                wake_any;
   logic                dbg_req;

   // only the core reset and the two interrupt pins are asynchronous
   ccrpm_sync #(
      .WIDTH   (SYNC_W),
      .RST_VAL (SYNC_RST_VAL)
   ) u_sync (
      .clk (CLK_SYS),
      .rst (RST),
      .ce  (CE),
      .d   ({FAST_INTERRUPT_N, NORMAL_INTERRUPT_N, CORE_RESET_N}),
      .q   (sync_q)
   );

   // debug side sits on the ungated clock so halts work in Standby
   ccrpm_dbg u_dbg (
      .clk        (CLK_SYS),
      .rst        (RST),
      .ce         (CE),
      .dbg_rst_n  (DEBUG_LOGIC_RESET_N),
      .dbg_bus_en (DEBUG_BUS_CLOCK_ENABLE),
      .halt_cmd   (DEBUG_HALT_CMD),
      .halt_taken (DEBUG_HALT_TAKEN),
      .ext_req    (EXTERNAL_DEBUG_REQUEST),
      .dbg_req    (dbg_req),
      .dbg_rst    (DEBUG_RESET_OUT),
      .dbg_stb    (DEBUG_BUS_STROBE)
   );

   assign core_ok = sync_q[SYNC_CORE_RST];
   assign irq_any = !sync_q[SYNC_IRQ] || !sync_q[SYNC_FIQ];

   always_comb begin
      c_next      = c_reg;
      c_next.done = 1'b0;
      // masked or not, any interrupt and any debug request wake Standby, unless a clamp in interrupt-wait takes it to Dormant
      wake_any    = irq_any || dbg_req
                 || (c_reg.wfe_kind && c_reg.evt_pend);
      // events latch; a new event beats a same-cycle consume
      c_next.evt_pend = c_reg.evt_pend | EVENT_WAKE_IN;

      case (c_reg.st)
         ST_RESET: begin
            c_next.st = ST_RUN;
         end
         ST_RUN: begin
            if (WAIT_INTERRUPT_INSTR) begin
               c_next.wfe_kind = 1'b0;
               c_next.st       = ST_DRAIN;
            end else if (WAIT_EVENT_INSTR) begin
               if (c_reg.evt_pend) begin
                  // pending event: the wait completes at once
                  c_next.evt_pend = EVENT_WAKE_IN;
                  c_next.done     = 1'b1;
               end else begin
                  c_next.wfe_kind = 1'b1;
                  c_next.st       = ST_STOP;
               end
            end
         end
         ST_DRAIN: begin
            // barrier: earlier accesses finish before clocks stop
            if (!MEM_ACCESS_PENDING) begin
               c_next.st = ST_STOP;
            end
         end
         ST_STOP: begin
            c_next.st = ST_IDLE;
         end
         ST_IDLE: begin
            // a clamp means the controller chose power-down
            if (!c_reg.wfe_kind && RAM_ISOLATION_CLAMP) begin
               c_next.st = ST_DORM;
            end else if (wake_any) begin
               c_next.st = ST_WAKE;
               if (c_reg.wfe_kind) begin
                  c_next.evt_pend = EVENT_WAKE_IN;
               end
            end
         end
         ST_DORM: begin
            c_next.st = ST_DORM;
         end
         ST_WAKE: begin
            c_next.st   = ST_RUN;
            c_next.done = 1'b1;
         end
         default: begin
            c_next.st = ST_RESET;
         end
      endcase

      // core reset overrides every mode, Dormant included
      if (!core_ok) begin
         c_next.st       = ST_RESET;
         c_next.evt_pend = 1'b0;
         c_next.done     = 1'b0;
      end

      // outputs follow the next state so they leave flops directly
      c_next.cke      = (c_next.st == ST_RESET)
                     || (c_next.st == ST_RUN)
                     || (c_next.st == ST_DRAIN)
                     || (c_next.st == ST_WAKE);
      c_next.wfi_o    = !c_next.wfe_kind
                     && ((c_next.st == ST_IDLE)
                      || (c_next.st == ST_DORM));
      c_next.wfe_o    = c_next.wfe_kind
                     && (c_next.st == ST_IDLE);
      c_next.core_rst = (c_next.st == ST_RESET);
      c_next.barrier  = (c_next.st == ST_DRAIN);
      c_next.bus_stb  = SYSTEM_BUS_CLOCK_ENABLE
                     && c_next.cke;
      // retained arrays are fenced off while the core is unpowered
      c_next.ram_blk  = RAM_ISOLATION_CLAMP
                     || (c_next.st == ST_DORM);
      c_next.unit_en  = UNIT_BUSY
                      & {N_UNITS{c_next.cke}};

      case (c_next.st)
         ST_STOP,
         ST_IDLE: begin
            c_next.mode = MODE_STANDBY;
         end
         ST_DORM: begin
            c_next.mode = MODE_DORMANT;
         end
         default: begin
            c_next.mode = MODE_RUN;
         end
      endcase
   end

   // single clock for the whole block
   always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
         c_reg <= C_RST;
      end else if (CE) begin
         c_reg <= c_next;
      end
   end

   assign WAIT_INTERRUPT_IDLE_OUT = c_reg.wfi_o;
   assign WAIT_EVENT_IDLE_OUT     = c_reg.wfe_o;
   assign WAIT_INSTR_DONE         = c_reg.done;
   assign POWER_MODE              = c_reg.mode;
   assign CORE_CLOCK_ENABLE       = c_reg.cke;
   assign UNIT_CLOCK_ENABLE       = c_reg.unit_en;
   assign SYSTEM_BUS_STROBE       = c_reg.bus_stb;
   assign BARRIER_BUSY            = c_reg.barrier;
   assign RAM_INPUT_BLOCK         = c_reg.ram_blk;
   assign CORE_RESET_OUT          = c_reg.core_rst;
   assign DEBUG_REQUEST_OUT       = dbg_req;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   sequence s_wfe_take;
      CE && core_ok && (c_reg.st == ST_RUN) && !WAIT_INTERRUPT_INSTR
      && WAIT_EVENT_INSTR && !c_reg.evt_pend;
   endsequence

   sequence s_stop_step;
      CE && core_ok && (c_reg.st == ST_STOP);
   endsequence

   chk_wfi_after_stop: assert property (
      $rose(c_reg.wfi_o) |-> ($past(c_reg.st == ST_STOP) && !c_reg.cke))
      else $error("interrupt-wait flag rose before clocks stopped");

   chk_barrier_drain: assert property (
      (CE && core_ok && (c_reg.st == ST_DRAIN) && MEM_ACCESS_PENDING)
      |=> ((c_reg.st == ST_DRAIN) && c_reg.cke && c_reg.barrier))
      else $error("barrier left with accesses outstanding");

   chk_wfe_standby: assert property (
      s_wfe_take ##1 s_stop_step |=> (c_reg.wfe_o && !c_reg.wfi_o))
      else $error("event-wait standby flag missing");

   chk_irq_wake: assert property (
      (CE && core_ok && (c_reg.st == ST_IDLE) && irq_any
       && (c_reg.wfe_kind || !RAM_ISOLATION_CLAMP))
      |=> ((c_reg.st == ST_WAKE) && c_reg.cke))
      else $error("interrupt did not wake standby");

   chk_event_wake: assert property (
      (CE && core_ok && (c_reg.st == ST_IDLE) && c_reg.wfe_kind
       && c_reg.evt_pend) |=> (c_reg.st == ST_WAKE))
      else $error("pending event did not wake event-wait");

   chk_dormant_hold: assert property (
      (CE && core_ok && (c_reg.st == ST_DORM))
      |=> ((c_reg.st == ST_DORM) && c_reg.wfi_o && !c_reg.cke))
      else $error("dormant left without reset");

   chk_wake_restart: assert property (
      (c_reg.st == ST_WAKE)
      |-> (c_reg.cke && !c_reg.wfi_o && !c_reg.wfe_o && !c_reg.done))
      else $error("standby flag held after clocks restarted");

   chk_core_reset: assert property (
      (CE && !core_ok) |=> (c_reg.core_rst && (c_reg.st == ST_RESET)))
      else $error("core reset did not reset core state");

   chk_unit_gating: assert property (
      (|c_reg.unit_en) |-> c_reg.cke)
      else $error("unit clock enabled while core clocks stopped");

   chk_bus_strobe: assert property (
      (CE && SYSTEM_BUS_CLOCK_ENABLE && c_next.cke) |=> c_reg.bus_stb)
      else $error("system bus strobe missed");

   chk_dbg_standby: assert property (
      (CE && (c_reg.st == ST_IDLE))
      |=> (DEBUG_BUS_STROBE == $past(DEBUG_BUS_CLOCK_ENABLE)))
      else $error("debug strobe stopped in standby");

   chk_clamp_dormant: assert property (
      (CE && core_ok && (c_reg.st == ST_IDLE) && !c_reg.wfe_kind
       && RAM_ISOLATION_CLAMP)
      |=> ((c_reg.st == ST_DORM) && c_reg.ram_blk
           && (c_reg.mode == MODE_DORMANT)))
      else $error("clamp in interrupt-wait did not enter dormant");

   chk_event_latch: assert property (
      (CE && core_ok && EVENT_WAKE_IN) |=> c_reg.evt_pend)
      else $error("event input not latched");

endmodule
`default_nettype wire

// file: tb/ccrpm_pmc.sv
// Purpose: power controller model for dormant entry and exit
// Assumes: the core's interrupt-wait flag is registered
// Notes:   slow stretches every step so the bench can act in between
`timescale 1ns/100ps
`default_nettype none
module ccrpm_pmc (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // bench requests
   input  wire logic dorm_req,
   input  wire logic rst_req,
   input  wire logic slow,
   // core handshake
   input  wire logic idle_wfi,
   output var  logic core_rst_n,
   output var  logic clamp,
   output var  logic pwr_on
);
   logic [1:0] ph;
   int         cnt;
   logic       hold;

   assign core_rst_n = !(hold || rst_req);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph <= 2'h0;
         cnt <= 0;
         hold <= 1'b0;
         clamp <= 1'b0;
         pwr_on <= 1'b1;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end else begin
         case (ph)
            // the core only asks; dormant is chosen here
            2'h0: if (dorm_req && idle_wfi) begin
               clamp <= 1'b1;
               ph <= 2'h1;
               cnt <= slow ? 16 : 3;
            end
            2'h1: begin
               hold <= 1'b1;
               ph <= 2'h2;
               cnt <= slow ? 16 : 3;
            end
            2'h2: if (dorm_req) begin
               pwr_on <= 1'b0;
            end else begin
               pwr_on <= 1'b1;
               ph <= 2'h3;
               cnt <= slow ? 16 : 4;
            end
            default: begin
               // reset held until power has been back for a while
               hold <= 1'b0;
               clamp <= 1'b0;
               ph <= 2'h0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// file: tb/tb_core_clock_reset_power_modes.sv
// Purpose: self-checking bench for core clock, reset and power modes
// Assumes: CE driven by the bench; power controller model owns reset and clamp
// Notes:   a negedge monitor matches standby and completion events
`timescale 1ns/100ps
`default_nettype none
module tb_core_clock_reset_power_modes;
   import ccrpm_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, irq_n = 1'b1, fiq_n = 1'b1;
   logic dbg_rst_n = 1'b1, ext_dbg = 1'b0, evt = 1'b0, sys_en = 1'b1;
   logic dbg_en = 1'b1, wait_interrupt_instr = 1'b0, wait_event_instr = 1'b0, mem_pend = 1'b0;
   logic halt = 1'b0, halt_tk = 1'b0, dorm_req = 1'b0, rst_req = 1'b0;
   logic slow = 1'b0, ps, pd, p_wi = 1'b0, p_we = 1'b0, ce = 1'b1;
   logic [N_UNITS_DEF-1:0] busy = '1, pu;
   wire logic core_rst_n, clamp, pwr_on, wi, we, done, dreq, crst, drst;
   wire logic cce, sstb, dstb, bbusy, rblk;
   wire logic [MODE_W-1:0] mode;
   wire logic [N_UNITS_DEF-1:0] ucen;
   wire logic [5:0] obsv = {pwr_on, crst, dreq, done, we, wi};
   logic [4:0] notes[$];
   int n_errors = 0;
   int compares = 0;
   int cycles = 0;

   always #25 clk_sys = ~clk_sys;

   ccrpm_pmc u_pmc (.clk(clk_sys), .rst(rst), .dorm_req(dorm_req),
      .rst_req(rst_req), .slow(slow), .idle_wfi(wi),
      .core_rst_n(core_rst_n), .clamp(clamp), .pwr_on(pwr_on));

   ccrpm_top u_dut (.CLK_SYS(clk_sys), .RST(rst), .CE(ce),
      .CORE_RESET_N(core_rst_n), .DEBUG_LOGIC_RESET_N(dbg_rst_n),
      .NORMAL_INTERRUPT_N(irq_n), .FAST_INTERRUPT_N(fiq_n),
      .EXTERNAL_DEBUG_REQUEST(ext_dbg), .EVENT_WAKE_IN(evt),
      .RAM_ISOLATION_CLAMP(clamp), .SYSTEM_BUS_CLOCK_ENABLE(sys_en),
      .DEBUG_BUS_CLOCK_ENABLE(dbg_en), .WAIT_INTERRUPT_INSTR(wait_interrupt_instr),
      .WAIT_EVENT_INSTR(wait_event_instr), .MEM_ACCESS_PENDING(mem_pend),
      .DEBUG_HALT_CMD(halt), .DEBUG_HALT_TAKEN(halt_tk), .UNIT_BUSY(busy),
      .WAIT_INTERRUPT_IDLE_OUT(wi), .WAIT_EVENT_IDLE_OUT(we),
      .WAIT_INSTR_DONE(done), .POWER_MODE(mode), .CORE_CLOCK_ENABLE(cce),
      .UNIT_CLOCK_ENABLE(ucen), .SYSTEM_BUS_STROBE(sstb),
      .DEBUG_BUS_STROBE(dstb), .BARRIER_BUSY(bbusy), .RAM_INPUT_BLOCK(rblk),
      .CORE_RESET_OUT(crst), .DEBUG_RESET_OUT(drst),
      .DEBUG_REQUEST_OUT(dreq));

   task automatic summarize;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input bit ok, input string m);
      compares++;
      if (!ok) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // bounded wait on one observed flag, sampled at falling edges
   task automatic await(input int b, input logic v);
      int i;
      @(negedge clk_sys);
      for (i = 0; i < 60 && obsv[b] !== v; i++) @(negedge clk_sys);
      chk(obsv[b] === v, "handshake not seen");
   endtask

   task automatic take(input logic [4:0] got);
      logic [4:0] e;
      e = (notes.size() == 0) ? 5'h00 : notes.pop_front();
      chk(got === e, "unexpected standby or completion");
   endtask

   always @(negedge clk_sys) begin
      if (!rst && wi && !p_wi) take({2'h1, mode});
      if (!rst && we && !p_we) take({2'h2, mode});
      if (!rst && done) take({2'h3, mode});
      p_wi = wi;
      p_we = we;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic enter_wfi(input int hold);
      @(posedge clk_sys);
      mem_pend <= 1'b1;
      wait_interrupt_instr <= 1'b1;
      notes.push_back({2'h1, MODE_STANDBY});
      @(posedge clk_sys);
      wait_interrupt_instr <= 1'b0;
      repeat (hold) begin
         @(negedge clk_sys);
         chk(bbusy === 1'b1 && wi === 1'b0 && cce === 1'b1, "barrier");
         @(posedge clk_sys);
      end
      mem_pend <= 1'b0;
      await(0, 1'b1);
      chk(cce === 1'b0 && ucen === '0 && sstb === 1'b0, "clocks run");
      chk(mode === MODE_STANDBY && dstb === 1'b1, "debug strobe");
   endtask

   task automatic wake(input int k, input int b);
      notes.push_back({2'h3, MODE_RUN});
      @(posedge clk_sys);
      case (k)
         0: irq_n <= 1'b0;
         1: fiq_n <= 1'b0;
         2: ext_dbg <= 1'b1;
         3: halt <= 1'b1;
         default: evt <= 1'b1;
      endcase
      @(posedge clk_sys);
      halt <= 1'b0;
      evt <= 1'b0;
      await(b, 1'b0);
      chk(cce === 1'b1 && mode === MODE_RUN, "no restart on wake");
      await(2, 1'b1);
      @(posedge clk_sys);
      irq_n <= 1'b1;
      fiq_n <= 1'b1;
      ext_dbg <= 1'b0;
      halt_tk <= (k == 3);
      @(posedge clk_sys);
      halt_tk <= 1'b0;
      await(3, 1'b0);
   endtask

   initial begin
      void'($urandom(32'hA7C7));
      cyc(8);
      @(negedge clk_sys);
      chk(crst === 1'b1 && drst === 1'b1 && cce === 1'b1, "reset out");
      chk(mode === MODE_RUN && wi === 1'b0, "reset mode");
      @(posedge clk_sys);
      rst <= 1'b0;
      await(4, 1'b0);
      for (int r = 1; r <= 3; r++) begin
         for (int i = 0; i < 9; i++) begin
            @(posedge clk_sys);
            ps = sys_en;
            pd = dbg_en;
            pu = busy;
            sys_en <= (i % r == 0);
            dbg_en <= (i % r != 0);
            busy <= N_UNITS_DEF'($urandom);
            @(negedge clk_sys);
            chk(sstb === ps && dstb === pd, "bus strobe ratio");
            chk(ucen === pu, "unit gating");
            chk(cce === 1'b1 && mode === MODE_RUN, "run clocks");
         end
      end
      // clock enable low must freeze the strobe against a new bus enable
      @(posedge clk_sys);
      ce <= 1'b0;
      sys_en <= 1'b1;
      @(negedge clk_sys);
      ps = sstb;
      cyc(2);
      @(negedge clk_sys);
      chk(sstb === ps && ps === 1'b0, "clock enable freeze");
      @(posedge clk_sys);
      ce <= 1'b1;
      @(posedge clk_sys);
      sys_en <= 1'b1;
      dbg_en <= 1'b1;
      busy <= '1;
      wait_event_instr <= 1'b1;
      notes.push_back({2'h2, MODE_STANDBY});
      @(posedge clk_sys);
      wait_event_instr <= 1'b0;
      await(1, 1'b1);
      chk(wi === 1'b0 && cce === 1'b0, "event standby flag");
      wake(4, 1);
      for (int k = 0; k < 4; k++) begin
         enter_wfi(1 + int'($urandom % 8));
         if (k == 0) begin
            @(posedge clk_sys);
            evt <= 1'b1;
            @(posedge clk_sys);
            evt <= 1'b0;
            cyc(4);
            @(negedge clk_sys);
            chk(wi === 1'b1, "event woke interrupt wait");
         end
         wake(k, 0);
      end
      @(posedge clk_sys);
      wait_event_instr <= 1'b1;
      notes.push_back({2'h3, MODE_RUN});
      @(posedge clk_sys);
      wait_event_instr <= 1'b0;
      await(2, 1'b1);
      chk(we === 1'b0 && cce === 1'b1, "latched event lost");
      @(posedge clk_sys);
      dbg_en <= 1'b0;
      halt <= 1'b1;
      @(posedge clk_sys);
      halt <= 1'b0;
      dbg_en <= 1'b1;
      cyc(2);
      @(negedge clk_sys);
      chk(dreq === 1'b0, "halt without bus enable");
      @(posedge clk_sys);
      halt <= 1'b1;
      @(posedge clk_sys);
      halt <= 1'b0;
      rst_req <= 1'b1;
      await(4, 1'b1);
      chk(dreq === 1'b1 && drst === 1'b0, "core reset hit debug");
      @(posedge clk_sys);
      rst_req <= 1'b0;
      await(4, 1'b0);
      @(posedge clk_sys);
      dbg_rst_n <= 1'b0;
      cyc(2);
      @(negedge clk_sys);
      chk(drst === 1'b1 && dreq === 1'b0 && crst === 1'b0, "debug reset");
      @(posedge clk_sys);
      dbg_rst_n <= 1'b1;
      for (int s = 1; s >= 0; s--) begin
         @(posedge clk_sys);
         slow <= s[0];
         dorm_req <= 1'b1;
         enter_wfi(2);
         cyc(3);
         @(negedge clk_sys);
         chk(mode === MODE_DORMANT && rblk === 1'b1, "dormant entry");
         if (s == 1) begin
            @(posedge clk_sys);
            irq_n <= 1'b0;
            ext_dbg <= 1'b1;
            evt <= 1'b1;
            cyc(5);
            @(negedge clk_sys);
            chk(mode === MODE_DORMANT && wi === 1'b1, "left dormant");
            @(posedge clk_sys);
            irq_n <= 1'b1;
            ext_dbg <= 1'b0;
            evt <= 1'b0;
         end
         await(5, 1'b0);
         chk(crst === 1'b1 && rblk === 1'b1, "retention lost");
         @(posedge clk_sys);
         dorm_req <= 1'b0;
         await(4, 1'b0);
         chk(mode === MODE_RUN && wi === 1'b0 && rblk === 1'b0, "restore");
      end
      cyc(4);
      chk(notes.size() == 0, "missing standby or completion");
      summarize();
   end
endmodule
`default_nettype wire
